//--- dv/dfa_line_model.sv
// line-side model: free recovered clock and a framed stream with zero payload
`timescale 1ns/100ps
module dfa_line_model (
    input  wire logic run_i,
    input  wire logic bad_p_i,
    output logic      line_clk_o,
    output logic      line_data_o
);
    int bit_pos;
    int blk;
    int sub;
    initial line_clk_o = 1'b0;
    initial line_data_o = 1'b0;
    always #32 line_clk_o = ~line_clk_o;
    // data moves on the falling edge, away from the sampling edge
    always @(negedge line_clk_o) begin
        if (!run_i) begin
            line_data_o <= 1'b0;
            bit_pos <= 0;
            blk <= 0;
            // start one subframe in, so the f-sync length decides the m-frame caught
            sub <= 1;
        end else begin
            if (bit_pos == 0 && (blk == 1 || blk == 7)) begin
                line_data_o <= 1'b1;
            end else if (bit_pos == 0 && blk == 0 && (sub == 2 || sub == 3)) begin
                line_data_o <= bad_p_i;
            end else begin
                line_data_o <= (bit_pos == 0 && blk == 0 && sub == 5);
            end
            bit_pos <= (bit_pos == dfa_pkg::BLOCK_LEN - 1) ? 0 : bit_pos + 1;
            if (bit_pos == dfa_pkg::BLOCK_LEN - 1) begin
                blk <= (blk + 1) % 8;
                sub <= (blk == 7) ? (sub + 1) % 7 : sub;
            end
        end
    end
endmodule // dfa_line_model

//--- dv/dfa_rx_frame_acq_sva.sv
// assertion checker on the frame acquisition ports
`timescale 1ns/100ps
module dfa_rx_frame_acq_sva #(
    parameter int BLOCK_LEN = 85,
    parameter int LOS_ZEROS = 128
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        line_clk_i,
    input wire logic        line_data_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        rx_frame_loss_flag_o,
    input wire logic        los_o
);
    int zero_run;
    int line_up;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // counters clear before the design's delayed line reset, so bounds lean safe
    always_ff @(posedge line_clk_i) begin
        if (rst_i || line_data_i) begin
            zero_run <= 0;
        end else if (zero_run < 4095) begin
            zero_run <= zero_run + 1;
        end
    end
    always_ff @(posedge line_clk_i) begin
        if (rst_i) begin
            line_up <= 0;
        end else if (line_up < 65535) begin
            line_up <= line_up + 1;
        end
    end
    sequence sd_write_s;
        reg_wr_i && reg_addr_i == dfa_pkg::ADDR_RX_SYNC_DETECT;
    endsequence
    sequence sd_read_s;
        reg_rd_i && !reg_wr_i && reg_addr_i == dfa_pkg::ADDR_RX_SYNC_DETECT;
    endsequence
    reset_values_a: assert property (disable iff (1'b0)
        rst_i |=> rx_frame_loss_flag_o && !los_o && reg_rdata_o == 8'h00)
        else $error("outputs not at reset values");
    sd_write_read_a: assert property (sd_write_s ##1 sd_read_s
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h03))
        else $error("sync-detect readback wrong");
    sd_reserved_a: assert property (sd_read_s |=> reg_rdata_o[7:2] == 6'h00)
        else $error("sync-detect reserved bits set");
    unmapped_read_a: assert property (reg_rd_i && reg_addr_i != dfa_pkg::ADDR_RX_CFG_STATUS
        && reg_addr_i != dfa_pkg::ADDR_RX_EVENT_STATUS && reg_addr_i != dfa_pkg::ADDR_RX_SYNC_DETECT
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    cfg_reserved_a: assert property (reg_rd_i && reg_addr_i == dfa_pkg::ADDR_RX_CFG_STATUS
        |=> {reg_rdata_o[7], reg_rdata_o[5], reg_rdata_o[3]} == 3'h0)
        else $error("status reserved bits set");
    in_frame_hold_a: assert property (!rx_frame_loss_flag_o |=> !rx_frame_loss_flag_o)
        else $error("left in-frame without reset");
    los_declare_a: assert property ($rose(zero_run >= LOS_ZEROS) |-> ##[1:12] los_o)
        else $error("loss of signal not declared");
    no_early_frame_a: assert property (line_up < 112 * BLOCK_LEN |-> rx_frame_loss_flag_o)
        else $error("in-frame declared too early");
endmodule // dfa_rx_frame_acq_sva

//--- dv/tb_dfa_rx_frame_acq.sv
// self-checking bench for receive frame acquisition
`timescale 1ns/100ps
module tb_dfa_rx_frame_acq;
    typedef struct {
        logic [7:0] sd;
        logic [7:0] cfg;
        int         bits;
        logic       out_of_frame;
    } dfa_row_type;
    localparam logic [15:0] CS = dfa_pkg::ADDR_RX_CFG_STATUS;
    localparam logic [15:0] EV = dfa_pkg::ADDR_RX_EVENT_STATUS;
    localparam logic [15:0] SD = dfa_pkg::ADDR_RX_SYNC_DETECT;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        line_clk_i;
    logic        line_data_i;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [7:0]  reg_rdata_o;
    logic        rx_frame_loss_flag_o;
    logic        los_o;
    logic        run = 1'b0;
    logic        bad_p = 1'b0;
    logic [7:0]  v;
    int          mismatches = 0;
    int          checks = 0;
    // sync-detect, config, line bits run, out-of-frame expected then
    dfa_row_type rows [5] = '{
        '{8'h00, 8'h04, 18000, 1'b0},
        '{8'h02, 8'h04, 18000, 1'b1},
        '{8'h01, 8'h04, 18000, 1'b0},
        '{8'h00, 8'h00, 14000, 1'b0},
        '{8'h00, 8'h04, 14000, 1'b1}
    };
    always #50 clk_i = ~clk_i;
    dfa_line_model line_side (
        .run_i       (run),
        .bad_p_i     (bad_p),
        .line_clk_o  (line_clk_i),
        .line_data_o (line_data_i)
    );
    dfa_rx_frame_acq dut (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .line_clk_i           (line_clk_i),
        .line_data_i          (line_data_i),
        .reg_addr_i           (reg_addr_i),
        .reg_wdata_i          (reg_wdata_i),
        .reg_wr_i             (reg_wr_i),
        .reg_rd_i             (reg_rd_i),
        .reg_rdata_o          (reg_rdata_o),
        .rx_frame_loss_flag_o (rx_frame_loss_flag_o),
        .los_o                (los_o)
    );
    task automatic final_report();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t register read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t status output %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        @(posedge clk_i);
        #1;
        d = reg_rdata_o;
    endtask
    // config is written here and in the register checks, always while out of frame
    task automatic acquire(input logic [7:0] sd, input logic [7:0] cfg, input int bits, input logic bp);
        @(posedge clk_i);
        rst_i <= 1'b1;
        run   <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(SD, sd);
        wr(CS, cfg);
        bad_p <= bp;
        run   <= 1'b1;
        repeat (bits) @(posedge line_clk_i);
        @(posedge clk_i);
        #1;
    endtask
    initial begin
        repeat (90000) @(posedge clk_i);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            acquire(rows[i].sd, rows[i].cfg, rows[i].bits, 1'b0);
            chk_bit(rx_frame_loss_flag_o, rows[i].out_of_frame);
            rd(EV, v);
            chk_reg(v, {7'h00, ~rows[i].out_of_frame});
            rd(CS, v);
            chk_reg(v & 8'hbf, {3'h0, rows[i].out_of_frame, 1'b0, rows[i].cfg[2:0]});
        end
        @(posedge clk_i);
        rst_i <= 1'b1;
        run   <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
        chk_bit(rx_frame_loss_flag_o, 1'b1);
        chk_bit(los_o, 1'b0);
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CS, v);
        chk_reg(v & 8'hbf, 8'h14);
        rd(SD, v);
        chk_reg(v, 8'h00);
        // write then read back to back; read-only bits must drop
        @(posedge clk_i);
        reg_addr_i  <= SD;
        reg_wdata_i <= 8'hff;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
        reg_rd_i    <= 1'b1;
        @(posedge clk_i);
        reg_rd_i    <= 1'b0;
        @(posedge clk_i);
        #1;
        chk_reg(reg_rdata_o, 8'h03);
        wr(CS, 8'hff);
        rd(CS, v);
        chk_reg(v & 8'hbf, 8'h17);
        wr(16'h1116, 8'hff);
        rd(16'h1116, v);
        chk_reg(v, 8'h00);
        repeat (200) @(posedge line_clk_i);
        @(posedge clk_i);
        #1;
        chk_bit(los_o, 1'b1);
        acquire(8'h00, 8'h04, 18000, 1'b1);
        chk_bit(rx_frame_loss_flag_o, 1'b1);
        rd(EV, v);
        chk_reg(v, 8'h02);
        final_report();
    end
endmodule // tb_dfa_rx_frame_acq
bind dfa_rx_frame_acq dfa_rx_frame_acq_sva #(.BLOCK_LEN(BLOCK_LEN), .LOS_ZEROS(LOS_ZEROS)) u_sva (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_clk_i(line_clk_i),
    .line_data_i(line_data_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .rx_frame_loss_flag_o(rx_frame_loss_flag_o),
    .los_o(los_o)
);

//--- hw/dfa_rx_frame_acq.sv
// receive ds3 frame acquisition: f-bit search, m-bit search, parity check
`timescale 1ns/100ps
module dfa_rx_frame_acq #(
    parameter int BLOCK_LEN  = dfa_pkg::BLOCK_LEN,
    parameter int NUM_SEARCH = dfa_pkg::NUM_SEARCH,
    parameter int LOS_ZEROS  = dfa_pkg::LOS_ZEROS
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        line_clk_i,
    input  wire logic        line_data_i,
    input  wire logic [15:0] reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    output logic             rx_frame_loss_flag_o,
    output logic             los_o
);

    localparam int         IW      = (NUM_SEARCH > 1) ? $clog2(NUM_SEARCH) : 1;
    localparam logic [7:0] PH_LAST = 8'(2 * BLOCK_LEN - 1);
    localparam logic [6:0] BP_LAST = 7'(BLOCK_LEN - 1);
    localparam logic [15:0] LOS_LIM = 16'(LOS_ZEROS);

    function automatic logic [IW-1:0] first_one(input logic [NUM_SEARCH-1:0] v);
        logic [IW-1:0] r;
        r = '0;
        for (int k = NUM_SEARCH - 1; k >= 0; k--) begin
            if (v[k]) begin
                r = IW'(k);
            end
        end
        return r;
    endfunction

    function automatic logic addr_is(input logic [15:0] a, input logic [15:0] off);
        return a == off;
    endfunction

    // ---------------- line clock domain ----------------

    logic       line_rst;
    logic [2:0] cfg_line;
    logic       unique_en;
    logic       thr16;
    logic       valid_p;

    dfa_sync #(.WIDTH(1), .STAGES(3), .RESET_VAL(1'b1)) u_rst_sync (
        .clk_i (line_clk_i),
        .rst_i (1'b0),
        .d_i   (rst_i),
        .q_o   (line_rst)
    );

    logic [1:0] sd_reg;
    logic [2:0] cs_reg;

    // quasi-static settings; software should change them only while searching
    dfa_sync #(.WIDTH(3), .STAGES(3), .RESET_VAL({dfa_pkg::CFG_STATUS_RESET[dfa_pkg::CS_VALID_P_BIT],
                                                 dfa_pkg::SYNC_DETECT_RESET})) u_cfg_sync (
        .clk_i (line_clk_i),
        .rst_i (line_rst),
        .d_i   ({cs_reg[dfa_pkg::CS_VALID_P_BIT], sd_reg}),
        .q_o   (cfg_line)
    );

    assign unique_en = cfg_line[dfa_pkg::SD_UNIQUE_BIT];
    assign thr16     = cfg_line[dfa_pkg::SD_THR16_BIT];
    assign valid_p   = cfg_line[2];

    dfa_pkg::dfa_state_type state;
    dfa_pkg::dfa_state_type next_state;

    logic [7:0] phase;

    logic [NUM_SEARCH-1:0]      act;
    logic [NUM_SEARCH-1:0][7:0] cand;
    logic [NUM_SEARCH-1:0][1:0] fidx;
    logic [NUM_SEARCH-1:0][4:0] cnt;
    logic [NUM_SEARCH-1:0]      hit;
    logic [NUM_SEARCH-1:0]      match;
    logic [NUM_SEARCH-1:0]      grant;
    logic [NUM_SEARCH-1:0]      fsync_cand;
    logic [NUM_SEARCH-1:0]      others;
    logic [IW-1:0]              win;
    logic                       held;
    logic                       fsync;
    logic [4:0]                 thr;

    // free-running position within one f-bit spacing
    always_ff @(posedge line_clk_i) begin
        if (line_rst) begin
            phase <= 8'h00;
        end else if (phase == PH_LAST) begin
            phase <= 8'h00;
        end else begin
            phase <= phase + 8'h01;
        end
    end

    always_comb begin
        held       = 1'b0;
        grant      = '0;
        fsync_cand = '0;
        thr        = thr16 ? dfa_pkg::FSYNC_THR_LONG : dfa_pkg::FSYNC_THR_SHORT;
        for (int k = 0; k < NUM_SEARCH; k++) begin
            hit[k]   = act[k] && (cand[k] == phase);
            match[k] = line_data_i == dfa_pkg::F_PATTERN[2'h3 - fidx[k]];
            held     = held | hit[k];
            fsync_cand[k] = hit[k] && match[k] && (({1'b0, cnt[k]} + 6'h01) >= {1'b0, thr});
        end
        // a position already tracked, or just dropped, is never taken twice
        if ((state == dfa_pkg::ST_F_SEARCH) && line_data_i && !held && !(&act)) begin
            grant[first_one(~act)] = 1'b1;
        end
        win         = first_one(fsync_cand);
        others      = act;
        others[win] = 1'b0;
        fsync = (state == dfa_pkg::ST_F_SEARCH) && (|fsync_cand) &&
                (!unique_en || !(|others));
    end

    for (genvar g = 0; g < NUM_SEARCH; g++) begin : g_search
        always_ff @(posedge line_clk_i) begin
            if (line_rst || (state != dfa_pkg::ST_F_SEARCH)) begin
                act[g]  <= 1'b0;
                cand[g] <= 8'h00;
                fidx[g] <= 2'h0;
                cnt[g]  <= 5'h00;
            end else if (grant[g]) begin
                // a captured one is taken as the first f-bit of the pattern
                act[g]  <= 1'b1;
                cand[g] <= phase;
                fidx[g] <= 2'h1;
                cnt[g]  <= 5'h01;
            end else if (hit[g]) begin
                if (match[g]) begin
                    fidx[g] <= fidx[g] + 2'h1;
                    cnt[g]  <= (cnt[g] == 5'h1f) ? cnt[g] : cnt[g] + 5'h01;
                end else begin
                    act[g] <= 1'b0;
                    cnt[g] <= 5'h00;
                end
            end
        end
    end

    // frame position, aligned by the winning circuit and then by the m-bits
    logic [6:0] blk_pos;
    logic [2:0] blk;
    logic [2:0] sub;
    logic       end_sub;
    logic       end_mf;
    logic       ovh0;
    logic       fbit;
    logic       f_err;
    logic       m_slot;
    logic       m_err;
    logic       m_lock;
    logic       m_frame_ok;
    logic       msync;
    logic       acq_err;
    logic       p_slot;
    logic       p_err;
    logic       p_done;

    logic       m_locked;
    logic [1:0] m_hist;
    logic [1:0] m_cnt;
    logic       acc;
    logic       acc_full;
    logic       par_prev;
    logic       par_known;

    always_comb begin
        end_sub    = (blk_pos == BP_LAST) && (blk == dfa_pkg::BLK_LAST);
        end_mf     = end_sub && (sub == dfa_pkg::SUB_LAST);
        ovh0       = (blk_pos == 7'h00) && (blk == 3'h0);
        fbit       = (blk_pos == 7'h00) && blk[0];
        f_err      = fbit && (line_data_i != dfa_pkg::F_PATTERN[2'h3 - blk[2:1]]);
        m_slot     = ovh0 && m_locked && (sub >= dfa_pkg::SUB_M1);
        m_err      = m_slot && (line_data_i != dfa_pkg::M_PATTERN[2'(dfa_pkg::SUB_LAST - sub)]);
        m_lock     = (state == dfa_pkg::ST_M_SEARCH) && !m_locked && ovh0 &&
                     ({m_hist, line_data_i} == dfa_pkg::M_PATTERN);
        m_frame_ok = m_slot && (sub == dfa_pkg::SUB_LAST) && !m_err;
        msync      = (state == dfa_pkg::ST_M_SEARCH) && m_frame_ok &&
                     (m_cnt == (dfa_pkg::MSYNC_FRAMES - 2'h1));
        acq_err    = ((state == dfa_pkg::ST_M_SEARCH) || (state == dfa_pkg::ST_P_CHECK)) && (f_err || m_err);
        p_slot     = ovh0 && par_known && ((sub == dfa_pkg::SUB_P1) || (sub == dfa_pkg::SUB_P2));
        p_err      = p_slot && (line_data_i != par_prev);
        p_done     = (state == dfa_pkg::ST_P_CHECK) && p_slot && (sub == dfa_pkg::SUB_P2) && !p_err;
    end

    always_ff @(posedge line_clk_i) begin
        if (line_rst) begin
            blk_pos <= 7'h00;
            blk     <= 3'h0;
            sub     <= 3'h0;
        end else if (fsync) begin
            // the bit just checked is f-bit number fidx, block 2*fidx+1
            blk_pos <= 7'h01;
            blk     <= {fidx[win], 1'b1};
            sub     <= 3'h0;
        end else begin
            blk_pos <= (blk_pos == BP_LAST) ? 7'h00 : blk_pos + 7'h01;
            if (blk_pos == BP_LAST) begin
                blk <= blk + 3'h1;
            end
            if (m_lock) begin
                sub <= dfa_pkg::SUB_LAST;
            end else if (end_sub) begin
                sub <= (sub == dfa_pkg::SUB_LAST) ? 3'h0 : sub + 3'h1;
            end
        end
    end

    always_ff @(posedge line_clk_i) begin
        if (line_rst || (state == dfa_pkg::ST_F_SEARCH)) begin
            m_locked <= 1'b0;
            m_hist   <= 2'h3; // ones: two real m-bits must arrive before a lock
            m_cnt    <= 2'h0;
        end else begin
            if (ovh0 && !m_locked) begin
                m_hist <= {m_hist[0], line_data_i};
            end
            if (m_lock) begin
                m_locked <= 1'b1;
                m_cnt    <= 2'h1;
            end else if (m_frame_ok && (m_cnt != dfa_pkg::MSYNC_FRAMES)) begin
                m_cnt <= m_cnt + 2'h1;
            end
        end
    end

    // payload parity of each full m-frame, overhead bits excluded, compared against the next frame's p-bits
    always_ff @(posedge line_clk_i) begin
        if (line_rst || !m_locked) begin
            acc       <= 1'b0;
            acc_full  <= 1'b0;
            par_prev  <= 1'b0;
            par_known <= 1'b0;
        end else if (end_mf) begin
            par_prev  <= acc ^ line_data_i;
            par_known <= acc_full;
            acc_full  <= 1'b1;
            acc       <= 1'b0;
        end else if (blk_pos != 7'h00) begin
            acc <= acc ^ line_data_i;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            dfa_pkg::ST_F_SEARCH: begin
                if (fsync) begin
                    next_state = dfa_pkg::ST_M_SEARCH;
                end
            end
            dfa_pkg::ST_M_SEARCH: begin
                if (acq_err) begin
                    next_state = dfa_pkg::ST_F_SEARCH;
                end else if (msync) begin
                    next_state = valid_p ? dfa_pkg::ST_P_CHECK : dfa_pkg::ST_IN_FRAME;
                end
            end
            dfa_pkg::ST_P_CHECK: begin
                if (acq_err || p_err) begin
                    next_state = dfa_pkg::ST_F_SEARCH;
                end else if (p_done) begin
                    next_state = dfa_pkg::ST_IN_FRAME;
                end
            end
            dfa_pkg::ST_IN_FRAME: begin
                next_state = dfa_pkg::ST_IN_FRAME;
            end
            default: begin
                next_state = dfa_pkg::ST_F_SEARCH;
            end
        endcase
    end

    always_ff @(posedge line_clk_i) begin
        if (line_rst) begin
            state <= dfa_pkg::ST_F_SEARCH;
        end else begin
            state <= next_state;
        end
    end

    logic        oof_line;
    logic        los_line;
    logic [15:0] zero_run;
    logic        inframe_tgl;
    logic        perr_tgl;

    always_ff @(posedge line_clk_i) begin
        if (line_rst) begin
            oof_line <= 1'b1;
        end else begin
            oof_line <= next_state != dfa_pkg::ST_IN_FRAME;
        end
    end

    always_ff @(posedge line_clk_i) begin
        if (line_rst) begin
            zero_run <= 16'h0000;
            los_line <= 1'b0;
        end else if (line_data_i) begin
            zero_run <= 16'h0000;
            los_line <= 1'b0;
        end else begin
            zero_run <= (zero_run == 16'hffff) ? zero_run : zero_run + 16'h0001;
            los_line <= (zero_run + 16'h0001) >= LOS_LIM;
        end
    end

    // events cross as toggles so a slow reader never misses one
    always_ff @(posedge line_clk_i) begin
        if (line_rst) begin
            inframe_tgl <= 1'b0;
            perr_tgl    <= 1'b0;
        end else begin
            if ((next_state == dfa_pkg::ST_IN_FRAME) && (state != dfa_pkg::ST_IN_FRAME)) begin
                inframe_tgl <= ~inframe_tgl;
            end
            if (p_err && ((state == dfa_pkg::ST_P_CHECK) || (state == dfa_pkg::ST_IN_FRAME))) begin
                perr_tgl <= ~perr_tgl;
            end
        end
    end

    // ---------------- processor clock domain ----------------

    logic [3:0] stat_clk;
    logic [1:0] tgl_prev;
    logic [1:0] ev;
    logic [1:0] ev_set;
    logic       ev_clr;

    dfa_sync #(.WIDTH(4), .STAGES(3), .RESET_VAL(4'h1)) u_stat_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({perr_tgl, inframe_tgl, los_line, oof_line}),
        .q_o   (stat_clk)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tgl_prev <= 2'h0;
        end else begin
            tgl_prev <= stat_clk[3:2];
        end
    end

    assign ev_set = stat_clk[3:2] ^ tgl_prev;
    assign ev_clr = reg_rd_i && addr_is(reg_addr_i, dfa_pkg::ADDR_RX_EVENT_STATUS);

    // a new event in the reading cycle stays set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev <= 2'h0;
        end else begin
            ev <= (ev & ~{2{ev_clr}}) | ev_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sd_reg <= dfa_pkg::SYNC_DETECT_RESET;
        end else if (reg_wr_i && addr_is(reg_addr_i, dfa_pkg::ADDR_RX_SYNC_DETECT)) begin
            sd_reg <= reg_wdata_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_reg <= dfa_pkg::CFG_STATUS_RESET;
        end else if (reg_wr_i && addr_is(reg_addr_i, dfa_pkg::ADDR_RX_CFG_STATUS)) begin
            cs_reg <= reg_wdata_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_frame_loss_flag_o <= 1'b1;
            los_o                <= 1'b0;
        end else begin
            rx_frame_loss_flag_o <= stat_clk[0];
            los_o                <= stat_clk[1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (addr_is(reg_addr_i, dfa_pkg::ADDR_RX_CFG_STATUS)) begin
                // ais and idle are not detected, so they read as zero
                reg_rdata_o <= {1'b0, los_o, 1'b0, rx_frame_loss_flag_o, 1'b0, cs_reg};
            end else if (addr_is(reg_addr_i, dfa_pkg::ADDR_RX_SYNC_DETECT)) begin
                reg_rdata_o <= {6'h00, sd_reg};
            end else if (addr_is(reg_addr_i, dfa_pkg::ADDR_RX_EVENT_STATUS)) begin
                reg_rdata_o <= {6'h00, ev};
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

endmodule // dfa_rx_frame_acq

//--- hw/dfa_sync.sv
// multi-stage synchroniser for levels and toggles entering a clock domain
`timescale 1ns/100ps
module dfa_sync #(
    parameter int               WIDTH     = 1,
    parameter int               STAGES    = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [STAGES-1:0][WIDTH-1:0] chain;

    // stages feed only the agreement check below
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chain <= {STAGES{RESET_VAL}};
        end else begin
            chain <= {chain[STAGES-2:0], d_i};
        end
    end

    // a change counts only once the last two stages agree, so one metastable sample cannot pass
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= RESET_VAL;
        end else begin
            q_o <= (chain[STAGES-1] & chain[STAGES-2]) | (q_o & (chain[STAGES-1] | chain[STAGES-2]));
        end
    end

endmodule // dfa_sync

//--- include/dfa_pkg.sv
// constants and types for the receive ds3 frame acquisition block
// Notes on behaviour
// - after reset the framer acquires frames, starting in the f-bit search state.
// - f-bits repeat as 1,0,0,1 at their fixed spacing in the stream.
// - five independent search circuits each track their own f-bit candidate position.
// - by default f-bit sync needs ten consecutive correct f-bits on one circuit.
// - sync-detect bit 1 picks sixteen correct f-bits when one, ten when zero.
// - once f-bit sync is declared the framer moves to m-bit search.
// - sync-detect bit 0 enables unique-candidate qualification against mimicking payload.
// - with qualification, sync only if the other four circuits hold no candidate.
// - f-search, m-search and parity check are acquisition; exactly one mode holds.
// - entering in-frame leaves acquisition; in-frame then holds until reset.
// - the framer detects and declares defects such as loss of signal and p-bit errors.
// - m-bit search wants 0,1,0 m-bits; three good m-frames declare m-bit sync.
// - with valid-parity set, p-bits are checked; good enters in-frame, bad restarts.
// - entering in-frame raises a change-of-frame event and clears status bit 4.
package dfa_pkg;

    // register addresses on the microprocessor port
    localparam logic [15:0] ADDR_RX_CFG_STATUS   = 16'h1110;
    localparam logic [15:0] ADDR_RX_EVENT_STATUS = 16'h1112;
    localparam logic [15:0] ADDR_RX_SYNC_DETECT  = 16'h1114;

    // sync-detect fields
    localparam int SD_UNIQUE_BIT = 0;
    localparam int SD_THR16_BIT  = 1;
    localparam logic [1:0] SYNC_DETECT_RESET = 2'h0;

    // configuration and status fields
    localparam int CS_MSYNC_ALGO_BIT = 0;
    localparam int CS_FSYNC_ALGO_BIT = 1;
    localparam int CS_VALID_P_BIT    = 2;
    localparam int CS_OOF_BIT        = 4;
    localparam int CS_IDLE_BIT       = 5;
    localparam int CS_LOS_BIT        = 6;
    localparam int CS_AIS_BIT        = 7;
    localparam logic [2:0] CFG_STATUS_RESET = 3'h4;

    // event fields, cleared by reading
    localparam int EV_OOF_CHANGE_BIT = 0;
    localparam int EV_PERR_BIT       = 1;

    // f-bit search
    localparam int         NUM_SEARCH      = 5;
    localparam logic [3:0] F_PATTERN       = 4'h9;
    localparam logic [4:0] FSYNC_THR_SHORT = 5'h0a;
    localparam logic [4:0] FSYNC_THR_LONG  = 5'h10;

    // m-bit search
    localparam logic [2:0] M_PATTERN    = 3'h2;
    localparam logic [1:0] MSYNC_FRAMES = 2'h3;

    // frame geometry: block of one overhead bit plus payload, 8 blocks per subframe
    localparam int         BLOCK_LEN   = 85;
    localparam logic [2:0] BLK_LAST    = 3'h7;
    localparam logic [2:0] SUB_LAST    = 3'h6;
    localparam logic [2:0] SUB_P1      = 3'h2;
    localparam logic [2:0] SUB_P2      = 3'h3;
    localparam logic [2:0] SUB_M1      = 3'h4;

    // loss of signal: run of zeros on the recovered data
    localparam int LOS_ZEROS = 128;

    typedef enum logic [1:0] {
        ST_F_SEARCH,
        ST_M_SEARCH,
        ST_P_CHECK,
        ST_IN_FRAME
    } dfa_state_type;

endpackage
